// ### logic/psf_feature_regs.sv
// Contract
// - feature id 11h selects the non-operational power config, set from Dword 11.
// - a get of feature 11h returns the current setting in completion Dword 0.
// - with permissive_enable set, background work may exceed the non-op power limit.
// - with permissive_enable clear, background work never exceeds the non-op limit; here bg_power_allowed_o falls one cycle late.
// - with permissive off, thermal management may be off and resume may be slow.
// - writing permissive_enable as 1 when unsupported aborts with Invalid Field.
// - feature id 80h is the progress marker, unchanged across power states.
// - preboot_load_count is bits 7:0, bits 31:8 reserved, returned in Dword 0.
`timescale 1ns/1ps
`default_nettype none
module psf_feature_regs
  import psf_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // command request
  input  wire logic        req_valid_i,
  input  wire logic        req_set_i,
  input  wire logic [7:0]  req_fid_i,
  input  wire logic [31:0] req_dw11_i,
  // capability
  input  wire logic        permissive_supported_i,
  // power state context
  input  wire logic        in_nonop_state_i,
  input  wire logic        bg_work_pending_i,
  // completion
  output logic             cpl_valid_o,
  output logic [7:0]       cpl_status_o,
  output logic [31:0]      cpl_dw0_o,
  // power policy
  output logic             bg_power_allowed_o,
  output logic             thermal_power_allowed_o,
  output logic             perf_degraded_o,
  output logic             permissive_enable_o,
  output logic [7:0]       preboot_load_count_o
);
  psf_cmd_if cmd ();

  // feature addressed by the current request
  typedef enum logic [1:0] {
    sel_nonop,
    sel_marker,
    sel_unknown
  } psf_sel_t;

  psf_sel_t    req_sel;
  logic        is_noppc;
  logic        is_spm;
  logic        is_set;
  logic        is_get;
  logic        perm_reject;
  logic        bg_limited;
  logic        rd_nonop;
  logic        rd_marker;
  logic        held_set;
  logic        held_clr;
  logic        held_work_q;
  logic [31:0] rd_word;
  logic [7:0]  cpl_status_d;
  logic [31:0] cpl_dw0_d;

  assign is_noppc    = (req_fid_i == PSF_FID_NOPPC);
  assign is_spm      = (req_fid_i == PSF_FID_SPM);
  assign is_set      = req_valid_i && req_set_i;
  assign is_get      = req_valid_i && !req_set_i;
  assign perm_reject = req_dw11_i[PSF_PERM_BIT] && !permissive_supported_i;
  assign bg_limited  = in_nonop_state_i && !cmd.perm;
  assign rd_nonop    = (req_sel == sel_nonop);
  assign rd_marker   = (req_sel == sel_marker);

  always_comb begin
    req_sel = sel_unknown;
    if (is_noppc) begin
      req_sel = sel_nonop;
    end else if (is_spm) begin
      req_sel = sel_marker;
    end
  end

  // a refused set must leave the stored bit as it was
  assign cmd.wr_perm = is_set && is_noppc && !perm_reject;
  assign cmd.wr_plc  = is_set && is_spm;
  // the store takes only its own field, so reserved write bits go nowhere
  assign cmd.wdata   = req_dw11_i;

  psf_store u_store (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .cmd     (cmd)
  );

  // readback per bit: every reserved position is an explicit zero
  for (genvar gi = 0; gi < PSF_DW; gi = gi + 1) begin : g_rd_bit
    logic nonop_bit;
    logic marker_bit;
    if (gi == PSF_PERM_BIT) begin : g_perm
      assign nonop_bit = cmd.perm;
    end else begin : g_perm_rsv
      assign nonop_bit = 1'h0;
    end
    if (gi < PSF_PLC_W) begin : g_count
      assign marker_bit = cmd.plc[gi];
    end else begin : g_count_rsv
      assign marker_bit = 1'h0;
    end
    assign rd_word[gi] = (rd_nonop && nonop_bit) ||
                         (rd_marker && marker_bit);
  end

  // unknown ids share the invalid-field code, so the host sees one refusal kind
  // a get never fails for a known id
  always_comb begin
    cpl_status_d = PSF_SC_SUCCESS;
    unique case (req_sel)
      sel_nonop: begin
        if (req_set_i && perm_reject) begin
          cpl_status_d = PSF_SC_INV_FIELD;
        end
      end
      sel_marker: begin
        cpl_status_d = PSF_SC_SUCCESS;
      end
      sel_unknown: begin
        cpl_status_d = PSF_SC_INV_FID;
      end
    endcase
  end

  // sets answer with a zero Dword 0; only gets carry a stored value
  assign cpl_dw0_d = is_get ? rd_word : PSF_ZERO_DW;

  // completion: one cycle after the request
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cpl_valid_o <= 1'h0;
    end else begin
      cpl_valid_o <= req_valid_i;
    end
  end

  // status and Dword 0 hold until the next request
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cpl_status_o <= PSF_SC_SUCCESS;
    end else if (req_valid_i) begin
      cpl_status_o <= cpl_status_d;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cpl_dw0_o <= PSF_ZERO_DW;
    end else if (req_valid_i) begin
      cpl_dw0_o <= cpl_dw0_d;
    end
  end

  // work held back in a non-op state without permission counts as done once
  // nothing is pending, so slow resume ends with the backlog; set wins
  assign held_set = bg_limited && bg_work_pending_i;
  assign held_clr = !bg_work_pending_i;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      held_work_q <= 1'h0;
    end else if (held_set) begin
      held_work_q <= 1'h1;
    end else if (held_clr) begin
      held_work_q <= 1'h0;
    end
  end

  // registered view: the limit follows a change of state or bit one cycle late
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bg_power_allowed_o <= 1'h0;
    end else begin
      bg_power_allowed_o <= !bg_limited;
    end
  end

  // cooling may stay off whenever background work is held to the non-op limit
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      thermal_power_allowed_o <= 1'h0;
    end else begin
      thermal_power_allowed_o <= !bg_limited;
    end
  end

  // degraded only after resuming; drops one cycle after the non-op state is re-entered
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      perf_degraded_o <= 1'h0;
    end else begin
      perf_degraded_o <= held_work_q && !in_nonop_state_i;
    end
  end

  // copies of the stored values, one cycle behind the store
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      permissive_enable_o <= PSF_PERM_RST;
    end else begin
      permissive_enable_o <= cmd.perm;
    end
  end

  // no power state input reaches the count, so it persists across states
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      preboot_load_count_o <= PSF_PLC_RST;
    end else begin
      preboot_load_count_o <= cmd.plc;
    end
  end
endmodule : psf_feature_regs
`default_nettype wire

// ### pkg/psf_pkg.sv
package psf_pkg;
  localparam int           PSF_DW            = 32;
  localparam logic [7:0]   PSF_FID_NOPPC     = 8'h11;
  localparam logic [7:0]   PSF_FID_SPM       = 8'h80;
  localparam int           PSF_PERM_BIT      = 0;
  localparam int           PSF_PLC_W         = 8;
  localparam logic         PSF_PERM_RST      = 1'h0;
  localparam logic [7:0]   PSF_PLC_RST       = 8'h00;
  // completion status codes: generic status type
  localparam logic [7:0]   PSF_SC_SUCCESS    = 8'h00;
  localparam logic [7:0]   PSF_SC_INV_FIELD  = 8'h02;
  localparam logic [7:0]   PSF_SC_INV_FID    = 8'h02;
  localparam logic [31:0]  PSF_ZERO_DW       = 32'h0000_0000;
endpackage : psf_pkg

// ### pkg/psf_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
// decoded feature access between the top and the store
interface psf_cmd_if;
  logic        wr_perm;
  logic        wr_plc;
  logic [31:0] wdata;
  logic        perm;
  logic [7:0]  plc;
  modport ctl (output wr_perm, output wr_plc, output wdata, input perm, input plc);
  modport store (input wr_perm, input wr_plc, input wdata, output perm, output plc);
endinterface : psf_cmd_if
`default_nettype wire

// ### logic/psf_store.sv
`timescale 1ns/1ps
`default_nettype none
module psf_store
  import psf_pkg::*;
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // decoded access
  psf_cmd_if.store  cmd
);
  logic       perm_q;
  logic [7:0] plc_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      perm_q <= PSF_PERM_RST;
    end else if (cmd.wr_perm) begin
      perm_q <= cmd.wdata[PSF_PERM_BIT];
    end
  end

  // no power state input reaches this register, so it persists across states
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      plc_q <= PSF_PLC_RST;
    end else if (cmd.wr_plc) begin
      plc_q <= cmd.wdata[PSF_PLC_W-1:0];
    end
  end

  assign cmd.perm = perm_q;
  assign cmd.plc  = plc_q;
endmodule : psf_store
`default_nettype wire

// ### sim/psf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module psf_checker (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        req_valid_i,
  input wire logic        req_set_i,
  input wire logic [7:0]  req_fid_i,
  input wire logic [31:0] req_dw11_i,
  input wire logic        permissive_supported_i,
  input wire logic        in_nonop_state_i,
  input wire logic        bg_work_pending_i,
  input wire logic        cpl_valid_o,
  input wire logic [7:0]  cpl_status_o,
  input wire logic [31:0] cpl_dw0_o,
  input wire logic        bg_power_allowed_o,
  input wire logic        thermal_power_allowed_o,
  input wire logic        permissive_enable_o,
  input wire logic        perf_degraded_o,
  input wire logic [7:0]  preboot_load_count_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire get_nop = req_valid_i && !req_set_i && req_fid_i == 8'h11;
  wire bad_set = req_valid_i && req_set_i && req_fid_i == 8'h11 && req_dw11_i[0];
  // two steady cycles cover the one-cycle lag of the registered limits behind in_nonop_state_i
  wire held = in_nonop_state_i && !permissive_enable_o;
  wire spm_set = req_valid_i && req_set_i && req_fid_i == 8'h80;
  a_cpl_follows: assert property (req_valid_i |=> cpl_valid_o) else $error("no answer");
  a_cpl_single: assert property (!req_valid_i |=> !cpl_valid_o) else $error("stray answer");
  a_nop_reserved: assert property (get_nop |=> cpl_dw0_o[31:1] == 31'h0) else $error("nop rsv");
  a_spm_reserved: assert property (req_valid_i && req_fid_i == 8'h80 |=>
    cpl_dw0_o[31:8] == 24'h0 && cpl_status_o == 8'h00) else $error("spm rsv");
  a_refuse_perm: assert property (bad_set && !permissive_supported_i |=>
    cpl_status_o == 8'h02) else $error("not refused");
  a_accept_perm: assert property (bad_set && permissive_supported_i |=>
    cpl_status_o == 8'h00) else $error("refused");
  a_bg_permit: assert property (permissive_enable_o [*2] |->
    bg_power_allowed_o && thermal_power_allowed_o) else $error("bg blocked");
  a_bg_limit: assert property (held [*2] |->
    !bg_power_allowed_o && !thermal_power_allowed_o) else $error("limit broken");
  a_count_steady: assert property (!spm_set [*2] |=>
    $stable(preboot_load_count_o)) else $error("count moved");
  a_perf_nonop: assert property (in_nonop_state_i |=>
    !perf_degraded_o) else $error("perf flag in non-op");
  a_perf_clears: assert property (!bg_work_pending_i |->
    ##2 !perf_degraded_o) else $error("perf flag stuck");
  c_get: cover property (get_nop ##1 cpl_dw0_o[0]);
  c_refuse: cover property (bad_set && !permissive_supported_i);
  c_held: cover property (held [*2]);
  c_perf: cover property (perf_degraded_o);
endmodule : psf_checker
bind psf_feature_regs psf_checker i_psf_checker (
  .clock_i                 (clock_i),
  .rst_i                   (rst_i),
  .req_valid_i             (req_valid_i),
  .req_set_i               (req_set_i),
  .req_fid_i               (req_fid_i),
  .req_dw11_i              (req_dw11_i),
  .permissive_supported_i  (permissive_supported_i),
  .in_nonop_state_i        (in_nonop_state_i),
  .bg_work_pending_i       (bg_work_pending_i),
  .cpl_valid_o             (cpl_valid_o),
  .cpl_status_o            (cpl_status_o),
  .cpl_dw0_o               (cpl_dw0_o),
  .bg_power_allowed_o      (bg_power_allowed_o),
  .thermal_power_allowed_o (thermal_power_allowed_o),
  .permissive_enable_o     (permissive_enable_o),
  .perf_degraded_o         (perf_degraded_o),
  .preboot_load_count_o    (preboot_load_count_o)
);
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  logic        clock_i = 0, rst_i = 1, vld = 0, set = 0, sup = 0, nop = 0, bgp = 0;
  logic [7:0]  fid = 8'h00;
  logic [31:0] dw = 32'h0;
  wire logic   cv, bga, tha, pen, pd;
  wire logic [7:0]  st, plc;
  wire logic [31:0] d0;
  int failures = 0, num_checks = 0;
  always #4 clock_i = ~clock_i;
  psf_feature_regs i_psf_feature_regs (.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(vld),
    .req_set_i(set), .req_fid_i(fid), .req_dw11_i(dw), .permissive_supported_i(sup),
    .in_nonop_state_i(nop), .bg_work_pending_i(bgp), .cpl_valid_o(cv), .cpl_status_o(st),
    .cpl_dw0_o(d0), .bg_power_allowed_o(bga), .thermal_power_allowed_o(tha),
    .perf_degraded_o(pd), .permissive_enable_o(pen), .preboot_load_count_o(plc));
  // the answer stands for one cycle after the taking edge, so read it just past it
  task automatic cmd(input logic s, input logic [7:0] f, input logic [31:0] w,
                     input logic [7:0] es, input logic [31:0] ed);
    @(posedge clock_i) {vld, set, fid, dw} <= {1'b1, s, f, w};
    @(posedge clock_i) vld <= 1'b0;
    #1;
    `CHK("valid", 1'b1, cv)
    `CHK("status", es, st)
    `CHK("dw0", ed, d0)
  endtask : cmd
  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial begin
    #20000;
    failures++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    cmd(1'b0, 8'h11, 32'h0, 8'h00, 32'h0);
    cmd(1'b0, 8'h00, 32'h0, 8'h02, 32'h0);
    cmd(1'b1, 8'h11, 32'hFFFFFFFF, 8'h02, 32'h0);
    cmd(1'b0, 8'h11, 32'h0, 8'h00, 32'h0);
    @(posedge clock_i) sup <= 1'b1;
    cmd(1'b1, 8'h11, 32'hFFFFFFFF, 8'h00, 32'h0);
    cmd(1'b0, 8'h11, 32'h0, 8'h00, 32'h1);
    `CHK("permissive", 1'b1, pen)
    @(posedge clock_i) nop <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1 `CHK("bg", 1'b1, bga)
    `CHK("thermal", 1'b1, tha)
    cmd(1'b1, 8'h11, 32'h0, 8'h00, 32'h0);
    repeat (2) @(posedge clock_i);
    #1 `CHK("bg", 1'b0, bga)
    `CHK("thermal", 1'b0, tha)
    cmd(1'b1, 8'h80, 32'hFFFFFFFE, 8'h00, 32'h0);
    cmd(1'b0, 8'h80, 32'h0, 8'h00, 32'hFE);
    cmd(1'b1, 8'h80, 32'hFF, 8'h00, 32'h0);
    @(posedge clock_i) bgp <= 1'b1;
    @(posedge clock_i) nop <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 `CHK("perf", 1'b1, pd)
    @(posedge clock_i) bgp <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 `CHK("perf", 1'b0, pd)
    cmd(1'b0, 8'h80, 32'h0, 8'h00, 32'hFF);
    `CHK("count", 8'hFF, plc)
    // pre-boot software at the top of the count writes it back unchanged
    cmd(1'b1, 8'h80, 32'hFF, 8'h00, 32'h0);
    cmd(1'b0, 8'h80, 32'h0, 8'h00, 32'hFF);
    cmd(1'b1, 8'h80, 32'h0, 8'h00, 32'h0);
    cmd(1'b0, 8'h80, 32'h0, 8'h00, 32'h0);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
